// *** rtl/adfc_top.sv ***
// Register bank for the audio filter chain and level control, reached over the three-wire port.
// Assumes resetn is the power-down pin and that level_gain_now and filter_block_power share clk.
//
// What this block does
// - Writing one to the initialise bit restarts all filter coefficients.
// - The initialise bit drops to zero by itself when initialisation ends.
// - Read-only level gain register at 0x0F; writes there do nothing.
// - Left and right input volumes, eight bits each, reset to E1H.
// - Left and right output volumes, eight bits each, reset to 91H.
// - Record and playback recovery references, eight bits, reset to E1H.
// - Recovery timing, limiter and gain-step writes ignored while filter powered.
// - Two-bit first recovery speed and wait period fields, reset to zero.
// - Two-bit limiter threshold field, reset to zero.
// - Three-bit recovery gain step field, reset to zero.
// - Level control enable bit, reset to off.
// - Soft mute bit mutes outputs, ignored while level control runs.
// - Second output volume, eight bits, reset to C1H.
// - Mic compensation: right nibble high, left nibble low, both reset zero.
// - Link bits make left volume drive both channels without copying it.
// - Filter chain source select, reset to level control output.
// - DAC source select, reset to serial input data.
// - Serial output source select, reset to filter chain output.
// - Stereo emphasis enable bit, reset to off.
// - Two-bit gain stage setting, reset to zero.
// - Gain compensation, second high-pass and low-pass enables, reset off.
// - Equaliser two, three and four enables, reset off.
// - Coefficient write enable bit, reset off, gates coefficient writes.
`timescale 1ns/1ps
module adfc_top
  import adfc_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYCLES_DFLT
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ctrl_sel_n,
  input  wire logic        ctrl_clk,
  input  wire logic        ctrl_data_in,
  output logic             ctrl_data_out,
  output logic             ctrl_data_oe_n,
  input  wire logic        filter_block_power,
  input  wire adfc_byte_t  level_gain_now,
  output adfc_byte_t       left_in_volume,
  output adfc_byte_t       right_in_volume,
  output adfc_byte_t       left_out_volume,
  output adfc_byte_t       right_out_volume,
  output adfc_byte_t       record_recovery_ref,
  output adfc_byte_t       playback_recovery_ref,
  output logic [1:0]       first_recovery_speed,
  output logic [1:0]       recovery_wait_period,
  output logic [1:0]       limiter_threshold,
  output logic [2:0]       recovery_gain_step,
  output logic             alc_enable,
  output logic             soft_mute,
  output adfc_byte_t       out_volume_second,
  output logic [3:0]       left_mic_comp,
  output logic [3:0]       right_mic_comp,
  output logic             filter_chain_source,
  output logic             dac_source_select,
  output logic             serial_out_source,
  output logic             stereo_emphasis_enable,
  output logic [1:0]       gain_stage_setting,
  output logic             gain_comp_filter_enable,
  output logic             hpf2_enable,
  output logic             lpf_enable,
  output logic             equaliser_two_enable,
  output logic             equaliser_three_enable,
  output logic             equaliser_four_enable,
  output logic             coef_write_enable,
  output logic             coef_init_busy
);
  import adfc_pkg::*;

  adfc_reg_if reg_bus ();

  adfc_serial_port u_port (
    .clk            (clk),
    .resetn         (resetn),
    .ctrl_sel_n     (ctrl_sel_n),
    .ctrl_clk       (ctrl_clk),
    .ctrl_data_in   (ctrl_data_in),
    .ctrl_data_out  (ctrl_data_out),
    .ctrl_data_oe_n (ctrl_data_oe_n),
    .bus            (reg_bus.port)
  );

  adfc_byte_t       regs_r [NREG];
  adfc_byte_t       rd_part [NREG];
  logic [NREG-1:0]  wr_hit;
  adfc_byte_t       rdata_acc;
  adfc_byte_t       right_in_r;
  adfc_byte_t       right_out_r;
  logic             soft_mute_r;
  logic             init_bit_r;
  adfc_init_state_t init_state_r;
  adfc_init_state_t init_state_nxt;
  logic [15:0]      init_cnt_r;
  logic [15:0]      init_cnt_nxt;

  // Each register stores only its defined bits; locked bits keep their value while powered.
  generate
    for (genvar i = 0; i < NREG; i++)
    begin : g_reg
      wire        hit  = reg_bus.wr_stb && reg_bus.addr == REG_ADDR[i];
      wire [7:0]  keep = filter_block_power ? REG_LOCK[i] : 8'h00;
      wire [7:0]  nxt  = (regs_r[i] & keep) | (reg_bus.wdata & REG_MASK[i] & ~keep);
      assign wr_hit[i]  = hit;
      assign rd_part[i] = (reg_bus.addr == REG_ADDR[i]) ? regs_r[i] : 8'h00;
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          regs_r[i] <= REG_RST[i];
        else if (hit)
          regs_r[i] <= nxt;
      end
    end
  endgenerate

  // The gain read-back has no storage, so a write to it falls on no register.
  always_comb
  begin
    rdata_acc = 8'h00;
    if (reg_bus.addr == ADDR_GAIN_RB)
      rdata_acc = level_gain_now;
    if (reg_bus.addr == ADDR_INIT)
      rdata_acc[BIT_INIT] = init_bit_r;
    for (int k = 0; k < NREG; k++)
      rdata_acc = rdata_acc | rd_part[k];
  end
  assign reg_bus.rdata = rdata_acc;

  // The host is trusted to start this only once clocks run after power-down release.
  wire init_start = reg_bus.wr_stb && reg_bus.addr == ADDR_INIT && reg_bus.wdata[BIT_INIT];
  wire init_last  = init_cnt_r == 16'(INIT_CYCLES - 1);

  always_comb
  begin
    init_state_nxt = init_state_r;
    init_cnt_nxt   = init_cnt_r;
    unique case (init_state_r)
      ADFC_INIT_IDLE:
      begin
        init_cnt_nxt = 16'h0000;
        if (init_start)
          init_state_nxt = ADFC_INIT_RUN;
      end
      ADFC_INIT_RUN:
      begin
        init_cnt_nxt = init_cnt_r + 16'h0001;
        if (init_start)
          init_cnt_nxt = 16'h0000;
        else if (init_last)
          init_state_nxt = ADFC_INIT_IDLE;
      end
      default:
      begin
        init_state_nxt = ADFC_INIT_IDLE;
        init_cnt_nxt   = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      init_state_r <= ADFC_INIT_IDLE;
      init_cnt_r   <= 16'h0000;
      init_bit_r   <= 1'b0;
    end
    else
    begin
      init_state_r <= init_state_nxt;
      init_cnt_r   <= init_cnt_nxt;
      init_bit_r   <= init_state_nxt == ADFC_INIT_RUN;
    end
  end

  // Linked volumes steer the right channel from the left register but never rewrite the right one.
  wire ivol_link = regs_r[IDX_ROUTE][BIT_IN_VOLUME_LINK];
  wire ovol_link = regs_r[IDX_ROUTE][BIT_OUT_VOLUME_LINK];
  wire mute_nxt  = regs_r[IDX_MODE][BIT_SOFT_MUTE] & ~regs_r[IDX_MODE][BIT_ALC];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      right_in_r  <= REG_RST[IDX_RIN];
      right_out_r <= REG_RST[IDX_ROUT];
      soft_mute_r <= 1'b0;
    end
    else
    begin
      right_in_r  <= ivol_link ? regs_r[IDX_LIN] : regs_r[IDX_RIN];
      right_out_r <= ovol_link ? regs_r[IDX_LOUT] : regs_r[IDX_ROUT];
      soft_mute_r <= mute_nxt;
    end
  end

  assign left_in_volume          = regs_r[IDX_LIN];
  assign right_in_volume         = right_in_r;
  assign left_out_volume         = regs_r[IDX_LOUT];
  assign right_out_volume        = right_out_r;
  assign record_recovery_ref     = regs_r[IDX_RECREF];
  assign playback_recovery_ref   = regs_r[IDX_PBREF];
  assign first_recovery_speed    = regs_r[IDX_RTIM][RFST_LSB +: 2];
  assign recovery_wait_period    = regs_r[IDX_RTIM][WTM_LSB +: 2];
  assign limiter_threshold       = regs_r[IDX_MODE][LMTH_LSB +: 2];
  assign recovery_gain_step      = regs_r[IDX_MODE][RGAIN_LSB +: 3];
  assign alc_enable              = regs_r[IDX_MODE][BIT_ALC];
  assign soft_mute               = soft_mute_r;
  assign out_volume_second       = regs_r[IDX_OVOL2];
  assign left_mic_comp           = regs_r[IDX_MIC][MICL_LSB +: 4];
  assign right_mic_comp          = regs_r[IDX_MIC][MICR_LSB +: 4];
  assign filter_chain_source     = regs_r[IDX_ROUTE][BIT_FILTER_CHAIN_SOURCE];
  assign dac_source_select       = regs_r[IDX_ROUTE][BIT_DAC_SOURCE_SELECT];
  assign serial_out_source       = regs_r[IDX_ROUTE][BIT_SERIAL_OUT_SOURCE];
  assign stereo_emphasis_enable  = regs_r[IDX_ENA][BIT_STEREO_EMPHASIS_ENABLE];
  assign gain_stage_setting      = regs_r[IDX_ENA][GN_LSB +: 2];
  assign gain_comp_filter_enable = regs_r[IDX_ENA][BIT_EQ0];
  assign hpf2_enable             = regs_r[IDX_ENA][BIT_HPF];
  assign lpf_enable              = regs_r[IDX_ENA][BIT_LPF];
  assign equaliser_two_enable    = regs_r[IDX_ENB][BIT_EQ2];
  assign equaliser_three_enable  = regs_r[IDX_ENB][BIT_EQ3];
  assign equaliser_four_enable   = regs_r[IDX_ENB][BIT_EQ4];
  assign coef_write_enable       = regs_r[IDX_COEF][BIT_COEF_WRITE_ENABLE];
  assign coef_init_busy          = init_bit_r;

  // Busy lasts exactly INIT_CYCLES cycles unless restarted; keep INIT_CYCLES at most 65536, the reach of the 16-bit counter.
  localparam int CHK_INIT_MAX = INIT_CYCLES + 1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire wr_rtim  = reg_bus.wr_stb && reg_bus.addr == REG_ADDR[IDX_RTIM];
  wire wr_mode  = reg_bus.wr_stb && reg_bus.addr == REG_ADDR[IDX_MODE];
  wire wr_route = reg_bus.wr_stb && reg_bus.addr == REG_ADDR[IDX_ROUTE];
  wire wr_coef  = reg_bus.wr_stb && reg_bus.addr == ADDR_COEF_CTRL;

  chk_init_start_sets: assert property (init_start |=> coef_init_busy)
    else $error("initialise request did not raise the busy bit");
  chk_init_self_clears: assert property ($rose(coef_init_busy) |-> ##[1:CHK_INIT_MAX] $fell(coef_init_busy))
    else $error("initialise bit did not clear by itself");
  chk_gain_readback: assert property (reg_bus.addr == ADDR_GAIN_RB |-> reg_bus.rdata == level_gain_now)
    else $error("gain read-back does not show the level control gain");
  chk_volume_reset: assert property ($rose(resetn) |-> left_in_volume == REG_RST[IDX_LIN]
                                     && left_out_volume == REG_RST[IDX_LOUT]
                                     && out_volume_second == REG_RST[IDX_OVOL2])
    else $error("volume register left reset with a wrong value");
  chk_rtim_locked: assert property (wr_rtim && filter_block_power |=> $stable(regs_r[IDX_RTIM]))
    else $error("recovery timing changed while the filter was powered");
  chk_mode_lock_bits: assert property (wr_mode && filter_block_power
                                       |=> recovery_gain_step == $past(recovery_gain_step)
                                       && limiter_threshold == $past(limiter_threshold))
    else $error("limiter or gain step changed while the filter was powered");
  chk_mode_free_write: assert property (wr_mode |=> alc_enable == $past(reg_bus.wdata[BIT_ALC]))
    else $error("level control enable did not take the written value");
  chk_mute_under_alc: assert property (alc_enable |=> !soft_mute)
    else $error("soft mute active while level control runs");
  chk_in_link: assert property (ivol_link && $stable(ivol_link) |=> right_in_volume == $past(left_in_volume))
    else $error("linked right input volume does not follow the left");
  chk_route_write: assert property (wr_route |=> filter_chain_source == $past(reg_bus.wdata[BIT_FILTER_CHAIN_SOURCE])
                                    && dac_source_select == $past(reg_bus.wdata[BIT_DAC_SOURCE_SELECT]))
    else $error("routing selects did not take the written value");
  chk_coef_enable: assert property (wr_coef |=> coef_write_enable == $past(reg_bus.wdata[BIT_COEF_WRITE_ENABLE]))
    else $error("coefficient write enable did not take the written value");

  cov_init_done: cover property ($fell(coef_init_busy));
  cov_locked_write: cover property (wr_mode && filter_block_power);
  cov_gain_read: cover property (reg_bus.addr == ADDR_GAIN_RB && !ctrl_data_oe_n);
endmodule // adfc_top

// *** pkg/adfc_pkg.sv ***
// Constants, register map and types of the audio filter and level control register bank.
// Assumes one 100 MHz clock domain and the 16-bit three-wire control frame described below.
package adfc_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int NREG   = 14;

  typedef logic [ADDR_W-1:0] adfc_addr_t;
  typedef logic [DATA_W-1:0] adfc_byte_t;

  // Frame: write flag, seven address bits, eight data bits, all most significant first.
  localparam logic [4:0] CMD_BITS   = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  localparam adfc_addr_t ADDR_COEF_CTRL = 7'h0d;
  localparam adfc_addr_t ADDR_INIT      = 7'h0e;
  localparam adfc_addr_t ADDR_GAIN_RB   = 7'h0f;

  localparam int IDX_COEF   = 0;
  localparam int IDX_LIN    = 1;
  localparam int IDX_RIN    = 2;
  localparam int IDX_LOUT   = 3;
  localparam int IDX_ROUT   = 4;
  localparam int IDX_RECREF = 5;
  localparam int IDX_PBREF  = 6;
  localparam int IDX_RTIM   = 7;
  localparam int IDX_MODE   = 8;
  localparam int IDX_OVOL2  = 9;
  localparam int IDX_MIC    = 10;
  localparam int IDX_ROUTE  = 11;
  localparam int IDX_ENA    = 12;
  localparam int IDX_ENB    = 13;

  localparam adfc_addr_t REG_ADDR [NREG] = '{7'h0d, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25,
                                             7'h26, 7'h27, 7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e};
  localparam adfc_byte_t REG_RST  [NREG] = '{8'h00, 8'he1, 8'he1, 8'h91, 8'h91, 8'he1, 8'he1,
                                             8'h00, 8'h00, 8'hc1, 8'h00, 8'h17, 8'h00, 8'h00};
  localparam adfc_byte_t REG_MASK [NREG] = '{8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                                             8'h33, 8'hfb, 8'hff, 8'hff, 8'h1f, 8'h3f, 8'h0e};
  // Bits that hold their value while the filter block is powered.
  localparam adfc_byte_t REG_LOCK [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                             8'hff, 8'h3b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam int BIT_COEF_WRITE_ENABLE   = 0;
  localparam int BIT_INIT   = 0;
  localparam int RFST_LSB   = 0;
  localparam int WTM_LSB    = 4;
  localparam int LMTH_LSB   = 0;
  localparam int RGAIN_LSB  = 3;
  localparam int BIT_ALC    = 6;
  localparam int BIT_SOFT_MUTE  = 7;
  localparam int MICL_LSB   = 0;
  localparam int MICR_LSB   = 4;
  localparam int BIT_IN_VOLUME_LINK  = 0;
  localparam int BIT_OUT_VOLUME_LINK  = 1;
  localparam int BIT_FILTER_CHAIN_SOURCE  = 2;
  localparam int BIT_DAC_SOURCE_SELECT  = 3;
  localparam int BIT_SERIAL_OUT_SOURCE  = 4;
  localparam int BIT_STEREO_EMPHASIS_ENABLE   = 0;
  localparam int GN_LSB     = 1;
  localparam int BIT_EQ0    = 3;
  localparam int BIT_HPF    = 4;
  localparam int BIT_LPF    = 5;
  localparam int BIT_EQ2    = 1;
  localparam int BIT_EQ3    = 2;
  localparam int BIT_EQ4    = 3;

  localparam int INIT_CYCLES_DFLT = 32;

  typedef enum logic [1:0] {
    ADFC_INIT_IDLE = 2'b01,
    ADFC_INIT_RUN  = 2'b10
  } adfc_init_state_t;

endpackage

// *** pkg/adfc_reg_if.sv ***
// Internal register access carrier between the serial control port and the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface adfc_reg_if;
  adfc_pkg::adfc_addr_t addr;
  adfc_pkg::adfc_byte_t wdata;
  adfc_pkg::adfc_byte_t rdata;
  logic                 wr_stb;

  modport port (output addr, output wdata, output wr_stb, input rdata);
  modport regs (input addr, input wdata, input wr_stb, output rdata);
endinterface

// *** rtl/adfc_serial_port.sv ***
// Three-wire control port slave: turns serial frames into register writes and read-backs.
// Assumes the serial clock half period spans at least four system clocks.
`timescale 1ns/1ps
module adfc_serial_port
  import adfc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ctrl_sel_n,
  input  wire logic ctrl_clk,
  input  wire logic ctrl_data_in,
  output logic      ctrl_data_out,
  output logic      ctrl_data_oe_n,
  adfc_reg_if.port  bus
);
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic       clk_prev_r;
  logic [4:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic       is_write_r;
  adfc_addr_t addr_r;
  adfc_byte_t wdata_r;
  logic       wr_stb_r;
  logic [6:0] tx_r;

  wire sel       = ~pin_sync_r[2];
  wire sclk      = pin_sync_r[1];
  wire sdin      = pin_sync_r[0];
  wire rise      = sel & sclk & ~clk_prev_r;
  wire fall      = sel & ~sclk & clk_prev_r;
  wire in_frame  = bit_cnt_r != FRAME_BITS;
  wire read_ph   = ~is_write_r && bit_cnt_r >= CMD_BITS && in_frame;

  assign bus.addr   = addr_r;
  assign bus.wdata  = wdata_r;
  assign bus.wr_stb = wr_stb_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta_r <= 3'h7;
      pin_sync_r <= 3'h7;
      clk_prev_r <= 1'b1;
    end
    else
    begin
      pin_meta_r <= {ctrl_sel_n, ctrl_clk, ctrl_data_in};
      pin_sync_r <= pin_meta_r;
      clk_prev_r <= pin_sync_r[1];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_cnt_r  <= 5'h00;
      shift_r    <= 7'h00;
      is_write_r <= 1'b1;
      addr_r     <= 7'h00;
      wdata_r    <= 8'h00;
      wr_stb_r   <= 1'b0;
    end
    else
    begin
      wr_stb_r <= 1'b0;
      if (!sel)
        bit_cnt_r <= 5'h00;
      else if (rise && in_frame)
      begin
        shift_r   <= {shift_r[5:0], sdin};
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == CMD_BITS - 5'h01)
        begin
          addr_r     <= {shift_r[5:0], sdin};
          is_write_r <= shift_r[6];
        end
        if (bit_cnt_r == FRAME_BITS - 5'h01 && is_write_r)
        begin
          wdata_r  <= {shift_r[6:0], sdin};
          wr_stb_r <= 1'b1;
        end
      end
    end
  end

  // Read data leaves on falling edges so the host samples it on the next rising edge.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_r           <= 7'h00;
      ctrl_data_out  <= 1'b0;
      ctrl_data_oe_n <= 1'b1;
    end
    else if (!sel)
      ctrl_data_oe_n <= 1'b1;
    else if (fall && read_ph)
    begin
      ctrl_data_oe_n <= 1'b0;
      if (bit_cnt_r == CMD_BITS)
      begin
        ctrl_data_out <= bus.rdata[7];
        tx_r          <= bus.rdata[6:0];
      end
      else
      begin
        ctrl_data_out <= tx_r[6];
        tx_r          <= {tx_r[5:0], 1'b0};
      end
    end
  end
endmodule // adfc_serial_port

// *** verif/tb_adfc_top.sv ***
// Self-checking bench for the filter and level control register bank.
// Assumes the three-wire frame of the package: write flag, address, data, most significant first.
`timescale 1ns/1ps
module tb_adfc_top;
  import adfc_pkg::*;

  localparam int INIT_N = 400;
  localparam adfc_byte_t PAT [NREG] = '{8'h01, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc,
                                        8'h21, 8'h3b, 8'hde, 8'ha5, 8'h1c, 8'h35, 8'h0a};

  logic       clk = 1'b0;
  logic       resetn;
  logic       ctrl_sel_n;
  logic       ctrl_clk;
  logic       ctrl_data_in;
  logic       ctrl_data_out;
  logic       ctrl_data_oe_n;
  logic       filter_block_power;
  adfc_byte_t level_gain_now;
  adfc_byte_t liv, riv, lov, rov, rref, pref, ov2, q;
  logic [1:0] frs, rwp, lth, gns;
  logic [2:0] rgs;
  logic [3:0] lmc, rmc;
  logic       alc, smu, fcs, dss, sos, emph, gcf, hpf, lpf, eq2, eq3, eq4, cwe, busy;
  int         error_cnt = 0;
  int         checks = 0;
  int         busy_run = 0;
  int         busy_len = 0;

  always #5 clk = ~clk;

  adfc_top #(.INIT_CYCLES(INIT_N)) u_adfc_top (
    .clk(clk), .resetn(resetn), .ctrl_sel_n(ctrl_sel_n), .ctrl_clk(ctrl_clk),
    .ctrl_data_in(ctrl_data_in), .ctrl_data_out(ctrl_data_out), .ctrl_data_oe_n(ctrl_data_oe_n),
    .filter_block_power(filter_block_power), .level_gain_now(level_gain_now),
    .left_in_volume(liv), .right_in_volume(riv), .left_out_volume(lov), .right_out_volume(rov),
    .record_recovery_ref(rref), .playback_recovery_ref(pref), .first_recovery_speed(frs),
    .recovery_wait_period(rwp), .limiter_threshold(lth), .recovery_gain_step(rgs), .alc_enable(alc),
    .soft_mute(smu), .out_volume_second(ov2), .left_mic_comp(lmc), .right_mic_comp(rmc),
    .filter_chain_source(fcs), .dac_source_select(dss), .serial_out_source(sos),
    .stereo_emphasis_enable(emph), .gain_stage_setting(gns), .gain_comp_filter_enable(gcf),
    .hpf2_enable(hpf), .lpf_enable(lpf), .equaliser_two_enable(eq2), .equaliser_three_enable(eq3),
    .equaliser_four_enable(eq4), .coef_write_enable(cwe), .coef_init_busy(busy)
  );

  // Measures how long each initialisation keeps the busy flag up.
  always @(posedge clk)
    if (busy === 1'b1)
      busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      busy_len <= busy_run;
      busy_run <= 0;
    end

  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One frame; during the read data phase the host line toggles so a stale level cannot pass.
  task automatic xfer(input logic wr, input adfc_addr_t a, input adfc_byte_t d, output adfc_byte_t r);
    logic [15:0] f;
    f = {wr, a, d};
    r = 8'h00;
    ctrl_sel_n <= 1'b0;
    repeat (5) @(posedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      ctrl_clk <= 1'b0;
      ctrl_data_in <= (wr || i > 7) ? f[i] : ~ctrl_data_in;
      repeat (5) @(posedge clk);
      ctrl_clk <= 1'b1;
      repeat (5) @(posedge clk);
      if (!wr && i < 8)
        r[i] = ctrl_data_out;
    end
    ctrl_sel_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask

  task automatic wr(input adfc_addr_t a, input adfc_byte_t d);
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdchk(input adfc_addr_t a, input adfc_byte_t e);
    xfer(1'b0, a, 8'h00, q);
    check($sformatf("reg %h", a), q, e);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] watchdog expired");
    close_out;
  end

  initial
  begin
    resetn = 1'b0;
    ctrl_sel_n = 1'b1;
    ctrl_clk = 1'b1;
    ctrl_data_in = 1'b0;
    filter_block_power = 1'b0;
    level_gain_now = 8'h5a;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check("busy", busy, 0);
    check("in", {liv, riv, lov, rov, rref, pref}, 48'he1e1_9191_e1e1);
    check("route reset", {fcs, dss, sos}, 3'b101);
    check("pins idle", {ctrl_data_oe_n, ctrl_data_out}, 2'b10);
    for (int i = 0; i < NREG; i++)
      rdchk(REG_ADDR[i], REG_RST[i]);
    rdchk(ADDR_GAIN_RB, 8'h5a);
    wr(ADDR_GAIN_RB, 8'h00);
    level_gain_now <= 8'ha3;
    rdchk(ADDR_GAIN_RB, 8'ha3);
    rdchk(7'h30, 8'h00);
    for (int i = 0; i < NREG; i++)
    begin
      wr(REG_ADDR[i], PAT[i]);
      rdchk(REG_ADDR[i], PAT[i] & REG_MASK[i]);
    end
    check("vol", {liv, riv, lov, rov, rref, pref}, 48'h1234_5678_9abc);
    check("alc", {frs, rwp, lth, rgs, alc, smu}, {2'b01, 2'b10, 2'b11, 3'b111, 2'b00});
    check("mic", {ov2, rmc, lmc}, {8'hde, 4'ha, 4'h5});
    check("route", {fcs, dss, sos, emph, gns, gcf, hpf, lpf, eq2, eq3, eq4, cwe},
          {4'b1111, 2'b10, 3'b011, 3'b101, 1'b1});
    wr(7'h2c, 8'h03);
    check("linked", {riv, rov, fcs, dss, sos}, {8'h12, 8'h56, 3'b000});
    rdchk(7'h21, 8'h34);
    rdchk(7'h23, 8'h78);
    filter_block_power <= 1'b1;
    wr(7'h26, 8'h00);
    rdchk(7'h26, 8'h21);
    wr(7'h27, 8'hc4);
    rdchk(7'h27, 8'hfb);
    check("mute", {alc, smu, lth, rgs}, {2'b10, 2'b11, 3'b111});
    filter_block_power <= 1'b0;
    wr(7'h27, 8'h80);
    check("mute", {alc, smu, lth, rgs}, {2'b01, 2'b00, 3'b000});
    wr(ADDR_INIT, 8'h00);
    check("busy", busy, 0);
    wr(ADDR_INIT, 8'h01);
    check("busy", busy, 1);
    rdchk(ADDR_INIT, 8'h01);
    repeat (INIT_N) @(posedge clk);
    check("busy", busy, 0);
    check("busy length", busy_len, INIT_N);
    rdchk(ADDR_INIT, 8'h00);
    close_out;
  end
endmodule // tb_adfc_top
